// ### rtl/irs_pkg.sv
// Constants for the interrupt and reset-cause status block
package irs_pkg;
  localparam logic [7:0] ADDR_CTRL_LO = 8'h0b;
  localparam logic [7:0] ADDR_CTRL_HI = 8'h8b;
  localparam logic [7:0] ADDR_PFLAGS  = 8'h0c;
  localparam logic [7:0] ADDR_PEN     = 8'h8c;
  localparam logic [7:0] ADDR_RCAUSE  = 8'h8e;
  localparam logic [7:0] ADDR_PCMASK  = 8'h96;
  localparam logic [7:0] ADDR_PORT    = 8'h05;
  localparam int BIT_GIE   = 7;
  localparam int BIT_PGE   = 6;
  localparam int BIT_T0E   = 5;
  localparam int BIT_EXE   = 4;
  localparam int BIT_PCE   = 3;
  localparam int BIT_T0F   = 2;
  localparam int BIT_EXF   = 1;
  localparam int BIT_PCF   = 0;
  localparam int BIT_NVM   = 7;
  localparam int BIT_ADC   = 6;
  localparam int BIT_CMP   = 3;
  localparam int BIT_T1    = 0;
  localparam int BIT_NOPOR = 1;
  localparam int BIT_NOBOD = 0;
  localparam logic [7:0] PERIPH_MASK  = 8'hc9;
  localparam logic [7:0] RCAUSE_MASK  = 8'h03;
  localparam logic [5:0] PORT_MASK    = 6'h3f;
  localparam logic [7:0] CTRL_RESET   = 8'h00;
  localparam logic [7:0] PERIPH_RESET = 8'h00;
  localparam logic [5:0] PCMASK_RESET = 6'h00;
endpackage : irs_pkg

// ### rtl/irs_sticky.sv
// One sticky flag: hardware set wins over software clear
`timescale 1ns/100ps
module irs_sticky
  import irs_pkg::*;
(
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic set_i,
  input  wire logic wr_i,
  input  wire logic wdata_i,
  output logic      flag_q
);
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      flag_q <= 1'b0;
    else if (set_i)
      flag_q <= 1'b1;
    else if (wr_i)
      flag_q <= wdata_i;
  end

  property p_set_holds;
    @(posedge clk) disable iff (!rst_n) set_i |=> flag_q;
  endproperty
  a_set_holds: assert property (p_set_holds) else $error("flag lost its set");

  property p_sticky;
    @(posedge clk) disable iff (!rst_n) (flag_q && !wr_i) |=> flag_q;
  endproperty
  a_sticky: assert property (p_sticky) else $error("flag dropped without write");
endmodule : irs_sticky

// ### rtl/irs_pin_change.sv
// Pin-change detection against value latched at last port access (read or write)
`timescale 1ns/100ps
module irs_pin_change
  import irs_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic [5:0] pins_i,
  input  wire logic [5:0] mask_i,
  input  wire logic       port_access_i,
  output logic            mismatch_q
);
  logic [5:0] latched_q;

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      latched_q <= 6'h00;
    else if (port_access_i)
      latched_q <= pins_i;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      mismatch_q <= 1'b0;
    else if (port_access_i)
      mismatch_q <= 1'b0;
    else
      mismatch_q <= |((pins_i ^ latched_q) & mask_i & PORT_MASK);
  end

  property p_masked;
    @(posedge clk) disable iff (!rst_n)
      (!port_access_i && ((pins_i ^ latched_q) & mask_i) == 6'h00) |=> !mismatch_q;
  endproperty
  a_masked: assert property (p_masked) else $error("mismatch from masked pin");

  property p_access_ends;
    @(posedge clk) disable iff (!rst_n) port_access_i |=> !mismatch_q;
  endproperty
  a_access_ends: assert property (p_access_ends) else $error("access kept mismatch");
endmodule : irs_pin_change

// ### rtl/irs_top.sv
// Interrupt enables, flags, request and reset-cause status
`timescale 1ns/100ps
module irs_top
  import irs_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic [7:0] addr,
  input  wire logic [7:0] wdata,
  input  wire logic       wr_en,
  input  wire logic       rd_en,
  output logic [7:0]      rdata_q,
  input  wire logic       timer0_wrap,
  input  wire logic       ext_pin_edge,
  input  wire logic [5:0] port_pins,
  input  wire logic       nvm_write_done,
  input  wire logic       conversion_done,
  input  wire logic       comparator_change,
  input  wire logic       timer1_wrap,
  input  wire logic       por_event,
  input  wire logic       brownout_event,
  output logic            irq_q
);
  function automatic logic hit(input logic [7:0] a, input logic [7:0] ref_a);
    hit = (a == ref_a);
  endfunction : hit

  logic       wr_ctrl;
  logic       wr_pf;
  logic       wr_pe;
  logic       wr_rc;
  logic       wr_pm;
  logic       port_access;
  logic [4:0] ctrl_en_q;
  logic [7:0] pen_q;
  logic [5:0] pcmask_q;
  logic [1:0] rcause_q;
  logic       mismatch_q;
  logic [2:0] core_flags;
  logic [7:0] pflags;
  logic [7:0] ctrl_rd;
  logic [2:0] core_set;
  logic [7:0] periph_set;

  assign wr_ctrl     = wr_en && (hit(addr, ADDR_CTRL_LO) || hit(addr, ADDR_CTRL_HI));
  assign wr_pf       = wr_en && hit(addr, ADDR_PFLAGS);
  assign wr_pe       = wr_en && hit(addr, ADDR_PEN);
  assign wr_rc       = wr_en && hit(addr, ADDR_RCAUSE);
  assign wr_pm       = wr_en && hit(addr, ADDR_PCMASK);
  assign port_access = (wr_en || rd_en) && hit(addr, ADDR_PORT);

  // Enable bits of the control register
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      ctrl_en_q <= CTRL_RESET[7:3];
    else if (wr_ctrl)
      ctrl_en_q <= wdata[7:3];
  end

  // Peripheral enables, only implemented bits kept
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      pen_q <= PERIPH_RESET;
    else if (wr_pe)
      pen_q <= wdata & PERIPH_MASK;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      pcmask_q <= PCMASK_RESET;
    else if (wr_pm)
      pcmask_q <= wdata[5:0] & PORT_MASK;
  end

  // Reset-cause bits: events clear, software writes back
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      rcause_q <= 2'b00;
    else
    begin
      if (por_event)
        rcause_q[BIT_NOPOR] <= 1'b0;
      else if (wr_rc)
        rcause_q[BIT_NOPOR] <= wdata[BIT_NOPOR];
      if (brownout_event)
        rcause_q[BIT_NOBOD] <= 1'b0;
      else if (wr_rc)
        rcause_q[BIT_NOBOD] <= wdata[BIT_NOBOD];
    end
  end

  irs_pin_change u_pin_change (
    .clk           (clk),
    .rst_n         (rst_n),
    .pins_i        (port_pins),
    .mask_i        (pcmask_q),
    .port_access_i (port_access),
    .mismatch_q    (mismatch_q)
  );

  assign core_set = {timer0_wrap, ext_pin_edge, mismatch_q};

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++)
    begin : g_core
      irs_sticky u_flag (
        .clk     (clk),
        .rst_n   (rst_n),
        .set_i   (core_set[gi]),
        .wr_i    (wr_ctrl),
        .wdata_i (wdata[gi]),
        .flag_q  (core_flags[gi])
      );
    end
  endgenerate

  always_comb
  begin
    periph_set          = 8'h00;
    periph_set[BIT_NVM] = nvm_write_done;
    periph_set[BIT_ADC] = conversion_done;
    periph_set[BIT_CMP] = comparator_change;
    periph_set[BIT_T1]  = timer1_wrap;
  end

  generate
    for (gi = 0; gi < 8; gi++)
    begin : g_periph
      if (PERIPH_MASK[gi])
      begin : g_impl
        irs_sticky u_flag (
          .clk     (clk),
          .rst_n   (rst_n),
          .set_i   (periph_set[gi]),
          .wr_i    (wr_pf),
          .wdata_i (wdata[gi]),
          .flag_q  (pflags[gi])
        );
      end
      else
      begin : g_none
        assign pflags[gi] = 1'b0;
      end
    end
  endgenerate

  assign ctrl_rd = {ctrl_en_q, core_flags};

  // Read data one cycle after the strobe
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      rdata_q <= 8'h00;
    else if (rd_en)
    begin
      if (hit(addr, ADDR_CTRL_LO) || hit(addr, ADDR_CTRL_HI))
        rdata_q <= ctrl_rd;
      else if (hit(addr, ADDR_PFLAGS))
        rdata_q <= pflags;
      else if (hit(addr, ADDR_PEN))
        rdata_q <= pen_q;
      else if (hit(addr, ADDR_RCAUSE))
        rdata_q <= {6'h00, rcause_q};
      else if (hit(addr, ADDR_PCMASK))
        rdata_q <= {2'b00, pcmask_q};
      else
        rdata_q <= 8'h00;
    end
    else
      rdata_q <= 8'h00;
  end

  // Interrupt request to the core
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      irq_q <= 1'b0;
    else
      irq_q <= ctrl_en_q[BIT_GIE-3] &&
               (|(ctrl_en_q[2:0] & core_flags) ||
                (ctrl_en_q[BIT_PGE-3] && |(pen_q & pflags)));
  end

  property p_no_periph_without_group;
    @(posedge clk) disable iff (!rst_n)
      (!ctrl_en_q[BIT_PGE-3] && !(|(ctrl_en_q[2:0] & core_flags))) |=> !irq_q;
  endproperty
  a_no_periph_without_group: assert property (p_no_periph_without_group)
    else $error("peripheral irq without group enable");

  property p_gie_gates;
    @(posedge clk) disable iff (!rst_n) !ctrl_en_q[BIT_GIE-3] |=> !irq_q;
  endproperty
  a_gie_gates: assert property (p_gie_gates) else $error("irq without global enable");

  property p_core_irq;
    @(posedge clk) disable iff (!rst_n)
      (ctrl_en_q[BIT_GIE-3] && ctrl_en_q[BIT_T0E-3] && core_flags[BIT_T0F]) |=> irq_q;
  endproperty
  a_core_irq: assert property (p_core_irq) else $error("missing timer0 irq");

  property p_alias_read;
    @(posedge clk) disable iff (!rst_n)
      (rd_en && hit(addr, ADDR_CTRL_HI)) |=> rdata_q == $past(ctrl_rd);
  endproperty
  a_alias_read: assert property (p_alias_read) else $error("alias read mismatch");

  property p_rcause_upper;
    @(posedge clk) disable iff (!rst_n)
      (rd_en && hit(addr, ADDR_RCAUSE)) |=> rdata_q[7:2] == 6'h00;
  endproperty
  a_rcause_upper: assert property (p_rcause_upper) else $error("reset cause upper set");

  property p_por_clears;
    @(posedge clk) disable iff (!rst_n) por_event |=> !rcause_q[BIT_NOPOR];
  endproperty
  a_por_clears: assert property (p_por_clears) else $error("por bit not cleared");

  property p_bod_clears;
    @(posedge clk) disable iff (!rst_n) brownout_event |=> !rcause_q[BIT_NOBOD];
  endproperty
  a_bod_clears: assert property (p_bod_clears) else $error("bod bit not cleared");

  property p_pen_unimpl;
    @(posedge clk) disable iff (!rst_n) (pen_q & ~PERIPH_MASK) == 8'h00;
  endproperty
  a_pen_unimpl: assert property (p_pen_unimpl) else $error("unimplemented enable set");

  property p_flag_sets;
    @(posedge clk) disable iff (!rst_n) conversion_done |=> pflags[BIT_ADC];
  endproperty
  a_flag_sets: assert property (p_flag_sets) else $error("adc flag not set");

  property p_nvm_sets;
    @(posedge clk) disable iff (!rst_n) nvm_write_done |=> pflags[BIT_NVM];
  endproperty
  a_nvm_sets: assert property (p_nvm_sets) else $error("nvm flag not set");

  property p_cmp_sets;
    @(posedge clk) disable iff (!rst_n) comparator_change |=> pflags[BIT_CMP];
  endproperty
  a_cmp_sets: assert property (p_cmp_sets) else $error("cmp flag not set");

  property p_t1_sets;
    @(posedge clk) disable iff (!rst_n) timer1_wrap |=> pflags[BIT_T1];
  endproperty
  a_t1_sets: assert property (p_t1_sets) else $error("timer1 flag not set");

  property p_t0_sets;
    @(posedge clk) disable iff (!rst_n) timer0_wrap |=> core_flags[BIT_T0F];
  endproperty
  a_t0_sets: assert property (p_t0_sets) else $error("timer0 flag not set");

  property p_ext_sets;
    @(posedge clk) disable iff (!rst_n) ext_pin_edge |=> core_flags[BIT_EXF];
  endproperty
  a_ext_sets: assert property (p_ext_sets) else $error("ext flag not set");

  property p_pc_sets;
    @(posedge clk) disable iff (!rst_n) mismatch_q |=> core_flags[BIT_PCF];
  endproperty
  a_pc_sets: assert property (p_pc_sets) else $error("change flag not set");

  property p_rd_idle;
    @(posedge clk) disable iff (!rst_n) !rd_en |=> rdata_q == 8'h00;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside read");

  property p_pe_write;
    @(posedge clk) disable iff (!rst_n) wr_pe |=> pen_q == ($past(wdata) & PERIPH_MASK);
  endproperty
  a_pe_write: assert property (p_pe_write) else $error("enable write lost");

  property p_pcmask_write;
    @(posedge clk) disable iff (!rst_n)
      wr_pm |=> {2'b00, pcmask_q} == ($past(wdata) & {2'b00, PORT_MASK});
  endproperty
  a_pcmask_write: assert property (p_pcmask_write) else $error("mask write lost");

  property p_rcause_write;
    @(posedge clk) disable iff (!rst_n)
      (wr_rc && !por_event && !brownout_event) |=>
        {6'h00, rcause_q} == ($past(wdata) & RCAUSE_MASK);
  endproperty
  a_rcause_write: assert property (p_rcause_write) else $error("cause write lost");

  property p_periph_irq;
    @(posedge clk) disable iff (!rst_n)
      (ctrl_en_q[BIT_GIE-3] && ctrl_en_q[BIT_PGE-3] && |(pen_q & pflags)) |=> irq_q;
  endproperty
  a_periph_irq: assert property (p_periph_irq) else $error("missing periph irq");

  property p_ext_irq;
    @(posedge clk) disable iff (!rst_n)
      (ctrl_en_q[BIT_GIE-3] && ctrl_en_q[BIT_EXE-3] && core_flags[BIT_EXF]) |=> irq_q;
  endproperty
  a_ext_irq: assert property (p_ext_irq) else $error("missing ext irq");

  property p_pc_irq;
    @(posedge clk) disable iff (!rst_n)
      (ctrl_en_q[BIT_GIE-3] && ctrl_en_q[BIT_PCE-3] && core_flags[BIT_PCF]) |=> irq_q;
  endproperty
  a_pc_irq: assert property (p_pc_irq) else $error("missing change irq");
endmodule : irs_top

// ### test/irs_src.sv
// Event source model: registers bench requests into event pulses one cycle later
`timescale 1ns/100ps
module irs_src
  import irs_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic [5:0] req,
  output logic [5:0]      pulse_q
);
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      pulse_q <= 6'h00;
    else
      pulse_q <= req;
  end
endmodule : irs_src

// ### test/irs_top_tb_top.sv
// Bench for the interrupt and reset-cause status block
`timescale 1ns/100ps
module irs_top_tb_top
  import irs_pkg::*;
;
  logic       clk            = 1'b0;
  logic       rst_n          = 1'b0;
  logic       wr_en          = 1'b0;
  logic       rd_en          = 1'b0;
  logic [7:0] addr           = 8'h00;
  logic [7:0] wdata          = 8'h00;
  logic [5:0] port_pins      = 6'h00;
  logic [5:0] req            = 6'h00;
  logic       por_event      = 1'b0;
  logic       brownout_event = 1'b0;
  logic [7:0] rdata_q;
  logic [5:0] ev;
  logic       irq_q;
  int         n_errors       = 0;
  int         cmp_count      = 0;
  logic [7:0] ra [7] = '{ADDR_CTRL_LO, ADDR_CTRL_HI, ADDR_PFLAGS, ADDR_PEN,
                         ADDR_RCAUSE, ADDR_PCMASK, 8'h0d};
  logic [7:0] pb [4] = '{8'h80, 8'h40, 8'h08, 8'h01};

  always #25 clk = ~clk;

  irs_src u_src (.clk(clk), .rst_n(rst_n), .req(req), .pulse_q(ev));

  irs_top dut (
    .clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr_en(wr_en),
    .rd_en(rd_en), .rdata_q(rdata_q), .timer0_wrap(ev[5]), .ext_pin_edge(ev[4]),
    .port_pins(port_pins), .nvm_write_done(ev[3]), .conversion_done(ev[2]),
    .comparator_change(ev[1]), .timer1_wrap(ev[0]), .por_event(por_event),
    .brownout_event(brownout_event), .irq_q(irq_q)
  );

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    addr  <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1 chk(rdata_q, exp);
  endtask : rd

  task automatic fire(input logic [5:0] v);
    @(posedge clk);
    req <= v;
    @(posedge clk);
    req <= 6'h00;
  endtask : fire

  task automatic pulse(input logic p);
    @(posedge clk);
    por_event      <= p;
    brownout_event <= !p;
    @(posedge clk);
    por_event      <= 1'b0;
    brownout_event <= 1'b0;
  endtask : pulse

  task automatic irq_is(input logic e);
    repeat (3) @(posedge clk);
    #1 chk({7'h00, irq_q}, {7'h00, e});
  endtask : irq_is

  task automatic stop_test;
    $display("compares=%0d errors=%0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : stop_test

  initial
  begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    irq_is(1'b0);
    // Reset values, both control addresses, unmapped place
    foreach (ra[i])
      rd(ra[i], 8'h00);
    wr(ADDR_CTRL_LO, 8'h38);
    rd(ADDR_CTRL_HI, 8'h38);
    wr(ADDR_CTRL_HI, 8'h00);
    rd(ADDR_CTRL_LO, 8'h00);
    wr(8'h0d, 8'hff);
    rd(8'h0d, 8'h00);
    // Flags set with every enable off
    fire(6'h3f);
    rd(ADDR_CTRL_LO, 8'h06);
    rd(ADDR_PFLAGS, PERIPH_MASK);
    irq_is(1'b0);
    wr(ADDR_PEN, 8'hff);
    rd(ADDR_PEN, PERIPH_MASK);
    wr(ADDR_CTRL_LO, 8'hc0);
    // One peripheral source at a time
    for (int i = 0; i < 4; i++)
    begin
      wr(ADDR_PFLAGS, 8'h00);
      wr(ADDR_PEN, pb[i]);
      irq_is(1'b0);
      fire(6'h08 >> i);
      rd(ADDR_PFLAGS, pb[i]);
      irq_is(1'b1);
    end
    wr(ADDR_CTRL_LO, 8'h80);
    irq_is(1'b0);
    rd(ADDR_PFLAGS, 8'h01);
    // Core group sources and global enable
    wr(ADDR_CTRL_LO, 8'ha0);
    irq_is(1'b0);
    fire(6'h20);
    irq_is(1'b1);
    wr(ADDR_CTRL_LO, 8'h24);
    irq_is(1'b0);
    rd(ADDR_CTRL_LO, 8'h24);
    wr(ADDR_CTRL_LO, 8'h90);
    fire(6'h10);
    irq_is(1'b1);
    rd(ADDR_CTRL_HI, 8'h92);
    // Pin change: masked pin, enabled pin, port access
    wr(ADDR_CTRL_LO, 8'h00);
    wr(ADDR_PCMASK, 8'h01);
    port_pins <= 6'h02;
    irq_is(1'b0);
    rd(ADDR_CTRL_LO, 8'h00);
    port_pins <= 6'h03;
    irq_is(1'b0);
    rd(ADDR_CTRL_LO, 8'h01);
    wr(ADDR_CTRL_LO, 8'h80);
    irq_is(1'b0);
    wr(ADDR_CTRL_LO, 8'h88);
    irq_is(1'b1);
    wr(ADDR_PORT, 8'h00);
    wr(ADDR_CTRL_LO, 8'h88);
    irq_is(1'b0);
    rd(ADDR_CTRL_LO, 8'h88);
    // A port read ends the mismatch as well
    port_pins <= 6'h02;
    irq_is(1'b1);
    rd(ADDR_PORT, 8'h00);
    wr(ADDR_CTRL_LO, 8'h88);
    irq_is(1'b0);
    rd(ADDR_CTRL_LO, 8'h88);
    // Reset-cause bits
    wr(ADDR_RCAUSE, 8'hff);
    rd(ADDR_RCAUSE, RCAUSE_MASK);
    pulse(1'b1);
    rd(ADDR_RCAUSE, 8'h01);
    pulse(1'b0);
    rd(ADDR_RCAUSE, 8'h00);
    wr(ADDR_RCAUSE, 8'h03);
    rd(ADDR_RCAUSE, 8'h03);
    // Second reset in mid-run
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    rd(ADDR_CTRL_LO, 8'h00);
    rd(ADDR_PFLAGS, 8'h00);
    rd(ADDR_RCAUSE, 8'h00);
    irq_is(1'b0);
    stop_test();
  end
endmodule : irs_top_tb_top
